// >>> rtl/smr_map.svh
// Purpose: offsets, field positions, reset values and counts of the mode register block
// Assumes: included by its bare name
// Notes: definitions only
`ifndef SMR_MAP_SVH
`define SMR_MAP_SVH
`define SMR_BA_MR1 3'h1
`define SMR_BA_MR2 3'h2
`define SMR_MR1_RESET 19'h00000
`define SMR_MR2_RESET 19'h00000
`define SMR_MR1_DLL_DIS 0
`define SMR_MR1_DRV_LO 1
`define SMR_MR1_RTT_LO 2
`define SMR_MR1_AL_LO 3
`define SMR_MR1_DRV_HI 5
`define SMR_MR1_RTT_MID 6
`define SMR_MR1_WLEV 7
`define SMR_MR1_RTT_HI 9
`define SMR_MR1_TDQS 11
`define SMR_MR1_QOFF 12
`define SMR_MR2_CWL_LO 3
`define SMR_MR2_ASR 6
`define SMR_MR2_SRT 7
`define SMR_MR2_RTTWR_LO 9
`define SMR_CWL_BASE 4'h5
`define SMR_BURST_CK 5'h4
`endif

// >>> rtl/smr_pkg.sv
// Purpose: types shared by the mode register block
// Assumes: nothing
// Notes: numbers live in smr_map.svh
package smr_pkg;
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [2:0] ba;
		logic [15:0] addr;
	} smr_cmd_t;
	typedef logic [18:0] smr_word_t;
	typedef enum logic [1:0] {SMR_IDLE = 2'b00, SMR_WAIT = 2'b01, SMR_BURST = 2'b11} smr_wstate_t;
	typedef struct packed {
		logic dll_dis;
		logic asr;
		logic srt;
	} smr_xfer_t;
	typedef struct packed {
		logic [1:0] drv_sel;
		logic qoff;
		logic tdqs_en;
		logic dm_en;
		logic wlev;
		logic dll_dis;
		logic [3:0] al;
		logic [3:0] cwl;
		logic [4:0] wl;
		logic [3:0] rtt_nom;
		logic [3:0] rtt_wr;
	} smr_cfg_t;
	typedef struct packed {
		smr_word_t mr1;
		smr_word_t mr2;
		smr_xfer_t xfer;
		logic req;
		logic [1:0] ack_sync;
		logic [1:0] rstpin_sync;
		smr_wstate_t wst;
		logic [4:0] wcnt;
		logic wdata_latch;
		smr_cfg_t cfg;
		logic [3:0] rtt_eff;
	} smr_link_state_t;
	typedef struct packed {
		logic [1:0] req_sync;
		logic req_seen;
		logic ack;
		smr_xfer_t cfg;
		logic sr_prev;
		logic dll_on;
		logic dll_reset;
		logic [1:0] hot_sync;
		logic rate2x;
	} smr_sys_state_t;
endpackage : smr_pkg

// >>> rtl/smr_mode_regs.sv
// Purpose: mode registers one and two of the sdram, written by load mode commands on ck
// Assumes: command pins, odt_in, read_active_in and cas_lat_in are synchronous to ck_in; self_refresh_in on sys_clk_in
// Notes: mode fields decoded on ck; dll and refresh rate control on sys_clk_in
`timescale 1ns/1ps
`include "smr_map.svh"

// Summary of operation
// - first register held until write, reset pin, power
// - second register held until write or power
// - first-register bit 0 selects dll enable
// - dll off in self refresh, restored on exit
// - bits 5,1 select output driver impedance
// - bit 12 set tri-states data and strobes
// - bit 11 enables tdqs on x8, drops mask
// - bits 9,6,2 pick nominal termination divisor
// - odt pin level switches nominal termination
// - writes swap in dynamic write termination
// - bit 7 enables write leveling mode
// - leveling without qoff limits termination values
// - bits 4,3 select additive latency
// - second-register bits 5..3 set write latency
// - first data latched after cwl plus al
// - auto self refresh doubles rate when hot
// - second-register bits 10,9 select write termination
module smr_mode_regs #(
	parameter bit IS_X8 = 1'b1
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic ck_in,
	input wire smr_pkg::smr_cmd_t cmd_in,
	input wire logic reset_pin_n_in,
	input wire logic odt_in,
	input wire logic read_active_in,
	input wire logic [3:0] cas_lat_in,
	input wire logic self_refresh_in,
	input wire logic hot_in,
	output smr_pkg::smr_cfg_t cfg_out,
	output logic [3:0] rtt_div_out,
	output logic wdata_latch_out,
	output logic write_burst_out,
	output logic dll_on_out,
	output logic dll_reset_out,
	output logic refresh_2x_out
);
	import smr_pkg::*;

	localparam smr_link_state_t LINK_RST = '{
		mr1: `SMR_MR1_RESET, mr2: `SMR_MR2_RESET, wst: SMR_IDLE, default: '0};

	smr_link_state_t link_reg, link_next;
	smr_sys_state_t sys_reg, sys_next;
	logic [1:0] lrst_sync_reg;
	logic lrst_n;
	logic mrs_hit;
	logic wr_hit;
	smr_word_t word_in;
	smr_xfer_t xfer_live;

	function automatic logic [3:0] rtt_nom_div(input logic [2:0] code);
		case (code)
			3'h1: rtt_nom_div = 4'h4;
			3'h2: rtt_nom_div = 4'h2;
			3'h3: rtt_nom_div = 4'h6;
			3'h4: rtt_nom_div = 4'hC;
			3'h5: rtt_nom_div = 4'h8;
			default: rtt_nom_div = 4'h0;
		endcase
	endfunction : rtt_nom_div

	function automatic logic [3:0] rtt_wr_div(input logic [1:0] code);
		case (code)
			2'h1: rtt_wr_div = 4'h4;
			2'h2: rtt_wr_div = 4'h2;
			default: rtt_wr_div = 4'h0;
		endcase
	endfunction : rtt_wr_div

	// power reset asserts at once, releases on ck
	always_ff @(posedge ck_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			lrst_sync_reg <= 2'b00;
		end else begin
			lrst_sync_reg <= {lrst_sync_reg[0], 1'b1};
		end
	end
	assign lrst_n = lrst_sync_reg[1];

	assign mrs_hit = !cmd_in.cs_n && !cmd_in.ras_n && !cmd_in.cas_n && !cmd_in.we_n;
	assign wr_hit = !cmd_in.cs_n && cmd_in.ras_n && !cmd_in.cas_n && !cmd_in.we_n;
	assign word_in = {cmd_in.ba, cmd_in.addr};
	assign xfer_live = '{dll_dis: link_reg.mr1[`SMR_MR1_DLL_DIS],
		asr: link_reg.mr2[`SMR_MR2_ASR], srt: link_reg.mr2[`SMR_MR2_SRT]};

	always_comb begin
		link_next = link_reg;
		link_next.rstpin_sync = {link_reg.rstpin_sync[0], reset_pin_n_in};
		link_next.ack_sync = {link_reg.ack_sync[0], sys_reg.ack};
		link_next.wdata_latch = 1'b0;
		// load mode command steered by bank address
		if (mrs_hit && cmd_in.ba == `SMR_BA_MR1) begin
			link_next.mr1 = word_in;
		end
		if (mrs_hit && cmd_in.ba == `SMR_BA_MR2) begin
			link_next.mr2 = word_in;
		end
		if (!link_reg.rstpin_sync[1]) begin
			link_next.mr1 = `SMR_MR1_RESET;
		end
		// toggle handshake toward sys clock; word held until acknowledged
		if (link_reg.req == link_reg.ack_sync[1] && link_reg.xfer != xfer_live) begin
			link_next.xfer = xfer_live;
			link_next.req = !link_reg.req;
		end
		// field decode, one ck after the load; wl one ck after cwl and al
		link_next.cfg.dll_dis = link_reg.mr1[`SMR_MR1_DLL_DIS];
		link_next.cfg.drv_sel = {link_reg.mr1[`SMR_MR1_DRV_HI],
			link_reg.mr1[`SMR_MR1_DRV_LO]};
		link_next.cfg.qoff = link_reg.mr1[`SMR_MR1_QOFF];
		link_next.cfg.tdqs_en = link_reg.mr1[`SMR_MR1_TDQS] && IS_X8;
		link_next.cfg.dm_en = !(link_reg.mr1[`SMR_MR1_TDQS] && IS_X8);
		link_next.cfg.wlev = link_reg.mr1[`SMR_MR1_WLEV];
		link_next.cfg.rtt_nom = rtt_nom_div({link_reg.mr1[`SMR_MR1_RTT_HI],
			link_reg.mr1[`SMR_MR1_RTT_MID], link_reg.mr1[`SMR_MR1_RTT_LO]});
		link_next.cfg.rtt_wr = rtt_wr_div(
			link_reg.mr2[`SMR_MR2_RTTWR_LO +: 2]);
		case (link_reg.mr1[`SMR_MR1_AL_LO +: 2])
			2'h1: link_next.cfg.al = cas_lat_in - 4'h1;
			2'h2: link_next.cfg.al = cas_lat_in - 4'h2;
			default: link_next.cfg.al = 4'h0;
		endcase
		link_next.cfg.cwl = {1'b0, link_reg.mr2[`SMR_MR2_CWL_LO +: 3]} + `SMR_CWL_BASE;
		link_next.cfg.wl = {1'b0, link_reg.cfg.cwl} + {1'b0, link_reg.cfg.al};
		// write data capture timing; a write during a pending one is ignored
		case (link_reg.wst)
			SMR_IDLE: begin
				if (wr_hit) begin
					link_next.wst = SMR_WAIT;
					link_next.wcnt = link_reg.cfg.wl - 5'h1;
				end
			end
			SMR_WAIT: begin
				if (link_reg.wcnt == 5'h0) begin
					link_next.wst = SMR_BURST;
					link_next.wcnt = `SMR_BURST_CK - 5'h1;
					link_next.wdata_latch = 1'b1;
				end else begin
					link_next.wcnt = link_reg.wcnt - 5'h1;
				end
			end
			SMR_BURST: begin
				if (link_reg.wcnt == 5'h0) begin
					link_next.wst = SMR_IDLE;
				end else begin
					link_next.wcnt = link_reg.wcnt - 5'h1;
				end
			end
			default: begin
				link_next.wst = SMR_IDLE;
			end
		endcase
		// effective termination at the pins
		link_next.rtt_eff = 4'h0;
		if (odt_in && !read_active_in) begin
			link_next.rtt_eff = link_reg.cfg.rtt_nom;
			if (link_reg.wst == SMR_BURST && link_reg.cfg.rtt_wr != 4'h0
					&& !link_reg.cfg.wlev) begin
				link_next.rtt_eff = link_reg.cfg.rtt_wr;
			end
			if (link_reg.cfg.wlev && !link_reg.cfg.qoff && link_reg.cfg.rtt_nom != 4'h2
					&& link_reg.cfg.rtt_nom != 4'h4 && link_reg.cfg.rtt_nom != 4'h6) begin
				link_next.rtt_eff = 4'h0;
			end
		end
	end

	always_ff @(posedge ck_in or negedge lrst_n) begin
		if (!lrst_n) begin
			link_reg <= LINK_RST;
		end else begin
			link_reg <= link_next;
		end
	end

	always_comb begin
		sys_next = sys_reg;
		sys_next.req_sync = {sys_reg.req_sync[0], link_reg.req};
		sys_next.req_seen = sys_reg.req_sync[1];
		sys_next.hot_sync = {sys_reg.hot_sync[0], hot_in};
		sys_next.sr_prev = self_refresh_in;
		sys_next.dll_reset = 1'b0;
		if (sys_reg.req_sync[1] != sys_reg.req_seen) begin
			sys_next.cfg = link_reg.xfer;
			sys_next.ack = sys_reg.req_sync[1];
		end
		sys_next.dll_on = !self_refresh_in && !sys_reg.cfg.dll_dis;
		if (!self_refresh_in && sys_reg.sr_prev && !sys_reg.cfg.dll_dis) begin
			sys_next.dll_reset = 1'b1;
		end
		sys_next.rate2x = sys_reg.cfg.srt || (sys_reg.cfg.asr && sys_reg.hot_sync[1]);
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sys_reg <= '0;
		end else begin
			sys_reg <= sys_next;
		end
	end

	assign cfg_out = link_reg.cfg;
	assign rtt_div_out = link_reg.rtt_eff;
	assign wdata_latch_out = link_reg.wdata_latch;
	assign write_burst_out = (link_reg.wst == SMR_BURST);
	assign dll_on_out = sys_reg.dll_on;
	assign dll_reset_out = sys_reg.dll_reset;
	assign refresh_2x_out = sys_reg.rate2x;

	// assertion helpers: age of the pending write and its latency
	logic [4:0] a_age_reg;
	logic [4:0] a_wl_reg;
	always_ff @(posedge ck_in or negedge lrst_n) begin
		if (!lrst_n) begin
			a_age_reg <= 5'h0;
			a_wl_reg <= 5'h0;
		end else if (link_reg.wst == SMR_IDLE && wr_hit) begin
			a_age_reg <= 5'h0;
			a_wl_reg <= link_reg.cfg.wl;
		end else begin
			a_age_reg <= a_age_reg + 5'h1;
		end
	end

	mr1_hold_a: assert property (@(posedge ck_in) disable iff (!lrst_n)
		!(mrs_hit && cmd_in.ba == `SMR_BA_MR1) && link_reg.rstpin_sync[1]
		|=> $stable(link_reg.mr1)) else $error("first mode register changed unbidden");
	mr2_hold_a: assert property (@(posedge ck_in) disable iff (!lrst_n)
		!(mrs_hit && cmd_in.ba == `SMR_BA_MR2) |=> $stable(link_reg.mr2))
		else $error("second mode register changed unbidden");
	load_route_a: assert property (@(posedge ck_in) disable iff (!lrst_n)
		mrs_hit && cmd_in.ba == `SMR_BA_MR1 && link_reg.rstpin_sync[1]
		|=> link_reg.mr1 == $past(word_in)) else $error("load not routed to register");
	qoff_hiz_a: assert property (@(posedge ck_in) disable iff (!lrst_n)
		link_reg.mr1[`SMR_MR1_QOFF] |=> cfg_out.qoff) else $error("output disable not applied");
	wl_latch_a: assert property (@(posedge ck_in) disable iff (!lrst_n)
		wdata_latch_out |-> a_age_reg == a_wl_reg) else $error("write data latched at wrong cycle");
	sequence burst_s;
		write_burst_out[*4] ##1 !write_burst_out;
	endsequence
	burst_len_a: assert property (@(posedge ck_in) disable iff (!lrst_n)
		wdata_latch_out |-> burst_s) else $error("write burst window wrong");
	dyn_rtt_a: assert property (@(posedge ck_in) disable iff (!lrst_n)
		write_burst_out && cfg_out.rtt_wr != 4'h0 && !cfg_out.wlev && odt_in && !read_active_in
		&& !(cfg_out.qoff == 1'b0 && cfg_out.wlev) |=> rtt_div_out == $past(cfg_out.rtt_wr))
		else $error("dynamic termination not applied");
	wlev_rtt_a: assert property (@(posedge ck_in) disable iff (!lrst_n)
		$past(cfg_out.wlev && !cfg_out.qoff) && rtt_div_out != 4'h0
		|-> rtt_div_out inside {4'h2, 4'h4, 4'h6}) else $error("leveling termination not allowed");
	odt_off_a: assert property (@(posedge ck_in) disable iff (!lrst_n)
		!odt_in |=> rtt_div_out == 4'h0) else $error("termination on with odt low");
	sequence sr_exit_s;
		!self_refresh_in && sys_reg.sr_prev && !sys_reg.cfg.dll_dis;
	endsequence
	sr_dll_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		sr_exit_s |=> dll_reset_out && dll_on_out ##1 !dll_reset_out)
		else $error("dll not reset on self refresh exit");
	sr_off_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		self_refresh_in |=> !dll_on_out) else $error("dll left on in self refresh");
	asr_rate_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		sys_reg.cfg.asr && sys_reg.hot_sync[1] |=> refresh_2x_out)
		else $error("hot case without doubled refresh");
endmodule : smr_mode_regs

// >>> bench/smr_ctrl_model.sv
// Purpose: memory controller model that issues load mode and write commands on ck
// Assumes: commands change on the falling edge of ck
// Notes: a deselected bus drives all four control pins high and shows the inverse of its last bank and address
`timescale 1ns/1ps
module smr_ctrl_model (
	input wire logic ck_in,
	output smr_pkg::smr_cmd_t cmd_out
);
	import smr_pkg::*;
	initial begin
		cmd_out = '1;
	end
	task automatic idle();
		cmd_out <= {4'hF, ~cmd_out.ba, ~cmd_out.addr};
	endtask : idle
	task automatic load(input logic [2:0] ba, input logic [15:0] a);
		logic [15:0] w;
		w = a;
		if (ba == 3'h1) begin
			w = w & ~16'hE500;
		end
		if (ba == 3'h2) begin
			w = w & ~16'hF907;
			if (w[6]) begin
				w[7] = 1'b0;
			end
		end
		@(negedge ck_in);
		cmd_out <= {4'h0, ba, w};
		@(negedge ck_in);
		idle();
		repeat (4) @(negedge ck_in); // gap before the next command
		// dll enabled: follow with a dll reset load to register zero
		if (ba == 3'h1 && !w[0]) begin
			@(negedge ck_in);
			cmd_out <= {4'h0, 3'h0, 16'h0100};
			@(negedge ck_in);
			idle();
			repeat (4) @(negedge ck_in);
		end
	endtask : load
	task automatic write_cmd();
		@(negedge ck_in);
		cmd_out <= {4'h4, 3'h0, 16'h0000};
		@(negedge ck_in);
		idle();
	endtask : write_cmd
endmodule : smr_ctrl_model

// >>> bench/tb_top.sv
// Purpose: self-checking bench of the mode register block
// Assumes: ck runs free at 48 ns, system clock at 40 ns
// Notes: inputs change on falling edges
`timescale 1ns/1ps
module tb_top;
	import smr_pkg::*;
	logic sys_clk = 1'b0;
	logic ck = 1'b0;
	logic rst_n = 1'b0;
	logic rpin_n = 1'b1;
	logic odt = 1'b1;
	logic rd = 1'b0;
	logic sr = 1'b0;
	logic hot = 1'b0;
	logic [3:0] cl = 4'h6;
	smr_cmd_t cmd;
	smr_cfg_t cfg;
	logic [3:0] rtt;
	logic latch, burst, dll_on, dll_rst, r2x;
	logic [2:0] pc;
	int fails = 0;
	int check_count = 0;
	int n;
	logic [15:0] ta [5] = '{16'h0004, 16'h0040, 16'h0044, 16'h0200, 16'h0204};
	logic [3:0] td [5] = '{4'h4, 4'h2, 4'h6, 4'hC, 4'h8};
	always #20 sys_clk = ~sys_clk;
	initial begin
		#7;
		forever #24 ck = ~ck;
	end
	smr_mode_regs u_dut (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .ck_in(ck), .cmd_in(cmd),
		.reset_pin_n_in(rpin_n), .odt_in(odt), .read_active_in(rd), .cas_lat_in(cl),
		.self_refresh_in(sr), .hot_in(hot), .cfg_out(cfg), .rtt_div_out(rtt),
		.wdata_latch_out(latch), .write_burst_out(burst), .dll_on_out(dll_on),
		.dll_reset_out(dll_rst), .refresh_2x_out(r2x));
	smr_ctrl_model u_ctl (.ck_in(ck), .cmd_out(cmd));
	task automatic chk(input logic [18:0] seen, input logic [18:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk
	task automatic ckw(input int k);
		repeat (k) @(negedge ck);
	endtask : ckw
	task automatic syw(input int k);
		repeat (k) @(negedge sys_clk);
	endtask : syw
	task automatic sr_cycle();
		@(negedge sys_clk);
		sr = 1'b1;
		syw(2);
		chk(dll_on, 1'b0);
		sr = 1'b0;
		pc = 3'h0;
		repeat (4) begin
			@(posedge sys_clk);
			#1 pc = pc + dll_rst;
		end
	endtask : sr_cycle
	task automatic complete_run();
		$display("checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run
	initial begin
		#200000;
		fails++;
		complete_run();
	end
	initial begin
		syw(2);
		rst_n = 1'b1;
		ckw(6);
		chk(cfg.cwl, 4'h5);
		chk(cfg.wl, 5'h05);
		chk(cfg.dm_en, 1'b1);
		chk(dll_on, 1'b1);
		$display("test defaults done");
		u_ctl.load(3'h1, 16'h1828);
		u_ctl.load(3'h2, 16'h0208);
		chk(cfg.qoff, 1'b1);
		chk(cfg.tdqs_en, 1'b1);
		chk(cfg.dm_en, 1'b0);
		chk(cfg.drv_sel, 2'h2);
		chk(cfg.al, 4'h5);
		chk(cfg.cwl, 4'h6);
		chk(cfg.wl, 5'h0B);
		chk(cfg.rtt_wr, 4'h4);
		u_ctl.write_cmd();
		for (n = 1; n < 40; n++) begin
			@(posedge ck);
			#1;
			if (latch === 1'b1) break;
		end
		chk(n, 11);
		chk(burst, 1'b1);
		@(posedge ck);
		#1 chk(rtt, 4'h4);
		ckw(8);
		chk(rtt, 4'h0);
		$display("test fields and write done");
		for (int i = 0; i < 5; i++) begin
			u_ctl.load(3'h1, ta[i]);
			chk(rtt, td[i]);
			chk(cfg.rtt_nom, td[i]);
		end
		rd = 1'b1;
		ckw(2);
		chk(rtt, 4'h0);
		rd = 1'b0;
		odt = 1'b0;
		ckw(2);
		chk(rtt, 4'h0);
		odt = 1'b1;
		u_ctl.load(3'h1, 16'h0284);
		chk(cfg.wlev, 1'b1);
		chk(rtt, 4'h0);
		u_ctl.load(3'h1, 16'h1284);
		chk(rtt, 4'h8);
		u_ctl.load(3'h1, 16'h0084);
		chk(rtt, 4'h4);
		$display("test termination done");
		u_ctl.load(3'h3, 16'hFFFF);
		chk(cfg.qoff, 1'b0);
		u_ctl.load(3'h1, 16'h1000);
		rpin_n = 1'b0;
		ckw(4);
		rpin_n = 1'b1;
		ckw(4);
		chk(cfg.qoff, 1'b0);
		chk(cfg.cwl, 4'h6);
		u_ctl.load(3'h1, 16'h0010);
		chk(cfg.al, 4'h4);
		chk(cfg.wl, 5'h0A);
		$display("test hold and reset pin done");
		sr_cycle();
		chk(pc, 3'h1);
		chk(dll_on, 1'b1);
		odt = 1'b0;
		u_ctl.load(3'h1, 16'h0001);
		chk(cfg.dll_dis, 1'b1);
		syw(20);
		sr_cycle();
		chk(pc, 3'h0);
		chk(dll_on, 1'b0);
		u_ctl.load(3'h2, 16'h0048); // write latency kept at six
		syw(20);
		chk(r2x, 1'b0);
		hot = 1'b1;
		syw(5);
		chk(r2x, 1'b1);
		hot = 1'b0;
		u_ctl.load(3'h2, 16'h0088); // write latency kept at six
		syw(20);
		chk(r2x, 1'b1);
		$display("test self refresh done");
		complete_run();
	end
endmodule : tb_top
